// ==== rtl/isadp_pkg.sv ====
package isadp_pkg;

   // ------------------------------------------------------------
   // Widths and register counts
   // ------------------------------------------------------------
   localparam int HOST_ADDR_W = 4;    // Offset bits inside a host block
   localparam int WIDE_REGS   = 8;    // 16-bit ports per main/game block
   localparam int MIDI_REGS   = 2;    // 8-bit ports in the MIDI block
   localparam int DSP_ADDR_W  = 4;    // Processor I/O port address bits
   localparam int DSP_PORTS   = 16;   // Processor I/O ports

   // ------------------------------------------------------------
   // Host side decode choices
   // ------------------------------------------------------------
   localparam logic [2:0] DIRECT_ACCESS_IDX = 3'h4;   // Main port that reaches processor memory

   // ------------------------------------------------------------
   // Processor port map
   // ------------------------------------------------------------
   localparam logic [3:0] PORT_TABLE_DATA = 4'h5;   // Extended table memory data
   localparam logic [2:0] PAIR_MIX_ONE    = 3'h4;   // Ports 8,9
   localparam logic [2:0] PAIR_MIX_TWO    = 3'h5;   // Ports A,B
   localparam logic [2:0] PAIR_MIX_CTL    = 3'h6;   // Ports C,D
   localparam logic [2:0] PAIR_EXT_PORT   = 3'h7;   // Ports E,F

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {HOST_IDLE, HOST_HOLD_WAIT, HOST_GRANTED} isadp_host_state_type;

   // Raw pin inputs, sampled as one word by the synchroniser
   typedef struct packed {
      logic                   mainSelN;
      logic                   midiSelN;
      logic                   gameSelN;
      logic                   rdN;
      logic                   wrN;
      logic [HOST_ADDR_W-1:0] addr;
      logic                   grantN;
      logic                   dmaActive;
      logic                   dspRdN;
      logic                   dspWrN;
      logic [DSP_ADDR_W-1:0]  dspAddr;
   } isadp_pins_type;

   localparam isadp_pins_type PINS_IDLE = '{mainSelN: 1'b1, midiSelN: 1'b1, gameSelN: 1'b1,
                                            rdN: 1'b1, wrN: 1'b1, addr: 4'h0, grantN: 1'b1,
                                            dmaActive: 1'b0, dspRdN: 1'b1, dspWrN: 1'b1,
                                            dspAddr: 4'h0};

   // ------------------------------------------------------------
   // One-hot decode of a port index
   // ------------------------------------------------------------
   function automatic logic [15:0] isadp_onehot(input logic [3:0] idx, input logic en);
      isadp_onehot = en ? (16'h0001 << idx) : 16'h0000;
   endfunction : isadp_onehot

endpackage : isadp_pkg

// ==== rtl/isadp_dsp_if.sv ====
interface isadp_dsp_if;
   logic [3:0]  addr;
   logic        rdAct;
   logic        wrAct;
   logic [15:0] portRd;
   logic [15:0] portWr;
   logic        mix1;
   logic        mix2;
   logic        mixer_control_select;
   logic        extWr;
   logic        extRd;
   logic        memWr;
   logic        memRd;

   modport host (output addr, rdAct, wrAct,
                 input portRd, portWr, mix1, mix2, mixer_control_select, extWr, extRd, memWr, memRd);
   modport dec  (input addr, rdAct, wrAct,
                 output portRd, portWr, mix1, mix2, mixer_control_select, extWr, extRd, memWr, memRd);
endinterface : isadp_dsp_if

// ==== rtl/isadp_dsp_decode.sv ====
module isadp_dsp_decode (
   // Processor port bundle, decoder side
   isadp_dsp_if.dec d
);
   logic [2:0] pairIdx;

   // ------------------------------------------------------------
   // Processor port decode, purely combinational so the access needs no wait
   // ------------------------------------------------------------
   assign pairIdx = d.addr[3:1];
   assign d.portRd = isadp_pkg::isadp_onehot(d.addr, d.rdAct);
   assign d.portWr = isadp_pkg::isadp_onehot(d.addr, d.wrAct);
   // Off-chip strobes: mixers are write only, the spare pair splits by direction
   assign d.mix1   = d.wrAct && (pairIdx == isadp_pkg::PAIR_MIX_ONE);
   assign d.mix2   = d.wrAct && (pairIdx == isadp_pkg::PAIR_MIX_TWO);
   assign d.mixer_control_select = d.wrAct && (pairIdx == isadp_pkg::PAIR_MIX_CTL);
   assign d.extWr  = d.wrAct && (pairIdx == isadp_pkg::PAIR_EXT_PORT);
   assign d.extRd  = d.rdAct && (pairIdx == isadp_pkg::PAIR_EXT_PORT);
   // Table memory: an input reads it, an output writes it
   assign d.memRd  = d.rdAct && (d.addr == isadp_pkg::PORT_TABLE_DATA);
   assign d.memWr  = d.wrAct && (d.addr == isadp_pkg::PORT_TABLE_DATA);

endmodule : isadp_dsp_decode

// ==== rtl/isadp_port_decode.sv ====
// Notes on behaviour
// - Three host groups: 16-bit main, 8-bit MIDI, game audio; each has own select.
// - Host access accepted only while its read or write strobe qualifies a block select.
// - Block makes its own register selects and drives no-wait and channel ready.
// - No-wait asserted for register ports, withheld for direct access and DMA.
// - Direct access requests hold; host kept waiting until processor grant arrives.
// - Grant may take any time; host cycle stays stalled throughout.
// - Processor decoder makes on-chip selects and off-chip select strobes.
// - Every decoded processor I/O access completes with no wait states.
// - Port 5 input reads table memory, output writes it via memory strobes.
module isadp_port_decode (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   // Host block selects from the outside decoder
   input  wire logic        mainGroupSelectN,
   input  wire logic        midiGroupSelectN,
   input  wire logic        gameAudioGroupSelectN,
   // Host strobes and offset
   input  wire logic        hostReadStrobeInN,
   input  wire logic        hostWriteStrobeInN,
   input  wire logic [3:0]  hostAddr,
   input  wire logic        dmaActive,
   // Host answers
   output logic             hostNoWaitOutN,
   output logic             hostChannelReadyOut,
   output logic             hostReadyOut,
   // Host register selects
   output logic [7:0]       mainRegRead,
   output logic [7:0]       mainRegWrite,
   output logic [1:0]       midiRegRead,
   output logic [1:0]       midiRegWrite,
   output logic [7:0]       gameRegRead,
   output logic [7:0]       gameRegWrite,
   // Processor hold handshake
   output logic             processorHoldReqN,
   input  wire logic        processorBusGrantN,
   // Processor I/O port
   input  wire logic        processorReadN,
   input  wire logic        processorStrobeN,
   input  wire logic [3:0]  processorAddr,
   output logic [15:0]      dspPortRead,
   output logic [15:0]      dspPortWrite,
   // Off-chip selects
   output logic             mixerLevelOneSelectN,
   output logic             mixerLevelTwoSelectN,
   output logic             mixerControlSelectN,
   output logic             extPortWriteSelectN,
   output logic             extPortReadSelectN,
   output logic             extMemoryWriteStrobeN,
   output logic             extMemoryReadEnableN
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      isadp_pkg::isadp_pins_type       pinS1;
      isadp_pkg::isadp_pins_type       pinS2;
      isadp_pkg::isadp_host_state_type hostSt;
      logic                            noWaitN;
      logic                            chanRdy;
      logic                            hostRdy;
      logic                            holdReqN;
      logic [7:0]                      mainRd;
      logic [7:0]                      mainWr;
      logic [1:0]                      midiRd;
      logic [1:0]                      midiWr;
      logic [7:0]                      gameRd;
      logic [7:0]                      gameWr;
      logic [15:0]                     portRd;
      logic [15:0]                     portWr;
      logic [6:0]                      extN;
   } isadp_state_type;

   localparam isadp_state_type STATE_RST = '{pinS1: isadp_pkg::PINS_IDLE, pinS2: isadp_pkg::PINS_IDLE,
                                             hostSt: isadp_pkg::HOST_IDLE, noWaitN: 1'b1,
                                             chanRdy: 1'b1, hostRdy: 1'b0, holdReqN: 1'b1,
                                             mainRd: 8'h00, mainWr: 8'h00, midiRd: 2'h0,
                                             midiWr: 2'h0, gameRd: 8'h00, gameWr: 8'h00,
                                             portRd: 16'h0000, portWr: 16'h0000, extN: 7'h7f};

   isadp_state_type       state_q;
   isadp_state_type       state_d;
   isadp_pkg::isadp_pins_type pinsRaw;
   isadp_pkg::isadp_pins_type p;
   logic                  hostRd;
   logic                  hostWr;
   logic                  mainHit;
   logic                  anyHit;
   logic                  directHit;
   logic [15:0]           wideOneHot;
   logic [15:0]           midiOneHot;
   isadp_dsp_if           dspBus ();

   // ------------------------------------------------------------
   // Input gathering; every pin passes two flops before use
   // ------------------------------------------------------------
   assign pinsRaw = '{mainSelN: mainGroupSelectN, midiSelN: midiGroupSelectN,
                      gameSelN: gameAudioGroupSelectN, rdN: hostReadStrobeInN,
                      wrN: hostWriteStrobeInN, addr: hostAddr, grantN: processorBusGrantN,
                      dmaActive: dmaActive, dspRdN: processorReadN, dspWrN: processorStrobeN,
                      dspAddr: processorAddr};
   assign p = state_q.pinS2;

   // Host qualification: a block select counts only under its strobe
   assign hostRd     = !p.rdN;
   assign hostWr     = !p.wrN;
   assign mainHit    = !p.mainSelN && (hostRd || hostWr);
   assign anyHit     = (!p.mainSelN || !p.midiSelN || !p.gameSelN) && (hostRd || hostWr);
   assign directHit  = mainHit && (p.addr[3:1] == isadp_pkg::DIRECT_ACCESS_IDX);
   // Wide groups index 16-bit ports, MIDI indexes bytes
   assign wideOneHot = isadp_pkg::isadp_onehot({1'b0, p.addr[3:1]}, 1'b1);
   assign midiOneHot = isadp_pkg::isadp_onehot({3'h0, p.addr[0]}, 1'b1);

   // ------------------------------------------------------------
   // Processor decoder, fed by synchronised strobes
   // ------------------------------------------------------------
   assign dspBus.addr  = p.dspAddr;
   assign dspBus.rdAct = !p.dspWrN && !p.dspRdN;
   assign dspBus.wrAct = !p.dspWrN && p.dspRdN;

   isadp_dsp_decode u_dsp_decode (
      .d (dspBus.dec)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      state_d       = state_q;
      state_d.pinS1 = pinsRaw;
      state_d.pinS2 = state_q.pinS1;
      // Register selects exist only while a strobe is active
      state_d.mainRd = (!p.mainSelN && hostRd) ? wideOneHot[7:0] : 8'h00;
      state_d.mainWr = (!p.mainSelN && hostWr) ? wideOneHot[7:0] : 8'h00;
      state_d.midiRd = (!p.midiSelN && hostRd) ? midiOneHot[1:0] : 2'h0;
      state_d.midiWr = (!p.midiSelN && hostWr) ? midiOneHot[1:0] : 2'h0;
      state_d.gameRd = (!p.gameSelN && hostRd) ? wideOneHot[7:0] : 8'h00;
      state_d.gameWr = (!p.gameSelN && hostWr) ? wideOneHot[7:0] : 8'h00;
      // No wait for plain register ports; memory path and DMA must stretch the cycle
      state_d.noWaitN = !(anyHit && !directHit && !p.dmaActive);
      // Direct access: hold the processor, hold off the host until the grant
      case (state_q.hostSt)
         isadp_pkg::HOST_IDLE: begin
            if (directHit) begin
               state_d.hostSt = isadp_pkg::HOST_HOLD_WAIT;
            end
         end
         isadp_pkg::HOST_HOLD_WAIT: begin
            // No timeout: the grant may take arbitrarily long
            if (!directHit) begin
               state_d.hostSt = isadp_pkg::HOST_IDLE;
            end else if (!p.grantN) begin
               state_d.hostSt = isadp_pkg::HOST_GRANTED;
            end
         end
         isadp_pkg::HOST_GRANTED: begin
            if (!directHit) begin
               state_d.hostSt = isadp_pkg::HOST_IDLE;
            end
         end
         default: begin
            state_d.hostSt = isadp_pkg::HOST_IDLE;
         end
      endcase
      state_d.holdReqN = !(state_d.hostSt != isadp_pkg::HOST_IDLE);
      state_d.chanRdy  = !(state_d.hostSt == isadp_pkg::HOST_HOLD_WAIT ||
                           (state_d.hostSt == isadp_pkg::HOST_IDLE && directHit));
      state_d.hostRdy  = (state_d.hostSt == isadp_pkg::HOST_GRANTED);
      // Processor side: one registered stage, never stalled
      state_d.portRd = dspBus.portRd;
      state_d.portWr = dspBus.portWr;
      state_d.extN   = ~{dspBus.mix1, dspBus.mix2, dspBus.mixer_control_select, dspBus.extWr,
                         dspBus.extRd, dspBus.memWr, dspBus.memRd};
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= STATE_RST;
      end else begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs, straight from flops
   // ------------------------------------------------------------
   assign hostNoWaitOutN        = state_q.noWaitN;
   assign hostChannelReadyOut   = state_q.chanRdy;
   assign hostReadyOut          = state_q.hostRdy;
   assign processorHoldReqN     = state_q.holdReqN;
   assign mainRegRead           = state_q.mainRd;
   assign mainRegWrite          = state_q.mainWr;
   assign midiRegRead           = state_q.midiRd;
   assign midiRegWrite          = state_q.midiWr;
   assign gameRegRead           = state_q.gameRd;
   assign gameRegWrite          = state_q.gameWr;
   assign dspPortRead           = state_q.portRd;
   assign dspPortWrite          = state_q.portWr;
   assign mixerLevelOneSelectN  = state_q.extN[6];
   assign mixerLevelTwoSelectN  = state_q.extN[5];
   assign mixerControlSelectN   = state_q.extN[4];
   assign extPortWriteSelectN   = state_q.extN[3];
   assign extPortReadSelectN    = state_q.extN[2];
   assign extMemoryWriteStrobeN = state_q.extN[1];
   assign extMemoryReadEnableN  = state_q.extN[0];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence s_direct_req;
      directHit && state_q.hostSt == isadp_pkg::HOST_IDLE;
   endsequence
   sequence s_waiting;
      !hostChannelReadyOut && !processorHoldReqN;
   endsequence

   AST_SEL_IN_STROBE: assert property ((mainRegRead != 8'h00) |-> $past(!p.rdN && !p.mainSelN))
      else $error("main read select without strobe");
   AST_SEL_ONEHOT: assert property ($onehot0(gameRegWrite) && $onehot0(mainRegRead))
      else $error("group select not one-hot");
   AST_QUALIFY: assert property ((p.rdN && p.wrN) |=> (midiRegRead == 2'h0 && midiRegWrite == 2'h0))
      else $error("MIDI select without host strobe");
   AST_NOWAIT_DMA: assert property (p.dmaActive |=> hostNoWaitOutN)
      else $error("no-wait during DMA");
   AST_NOWAIT_REG: assert property ((anyHit && !directHit && !p.dmaActive) |=> !hostNoWaitOutN)
      else $error("no-wait missing for register access");
   AST_HOLD_WAIT: assert property (s_direct_req |=> s_waiting)
      else $error("direct access did not stall host");
   AST_STALL_UNTIL_GRANT: assert property ((state_q.hostSt == isadp_pkg::HOST_HOLD_WAIT && p.grantN &&
                                            directHit) |=> s_waiting)
      else $error("host released before grant");
   AST_GRANT_RELEASE: assert property ((state_q.hostSt == isadp_pkg::HOST_HOLD_WAIT && !p.grantN &&
                                        directHit) |=> hostChannelReadyOut && hostReadyOut)
      else $error("grant did not release host");
   AST_TABLE_READ: assert property ((!p.dspWrN && !p.dspRdN && p.dspAddr == isadp_pkg::PORT_TABLE_DATA)
                                    |=> !extMemoryReadEnableN && extMemoryWriteStrobeN)
      else $error("table read enable missing");
   AST_DSP_NOWAIT: assert property ((!p.dspWrN && p.dspRdN) |=> $onehot(dspPortWrite))
      else $error("processor write not decoded next cycle");

endmodule : isadp_port_decode

// ==== tb/isadp_ext_decoder.sv ====
module isadp_ext_decoder (
   // Host bus address qualifiers
   input  wire logic        addrEnable,
   input  wire logic [10:0] busAddr,
   // Block selects and wide transfer flag
   output logic             mainSelN,
   output logic             midiSelN,
   output logic             gameSelN,
   output logic             wideIoN
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Default base decode
   // ------------------------------------------------------------
   // Pure logic, so selects follow the address with no delay at all
   always_comb begin
      mainSelN = !(!addrEnable && busAddr[10:4] == 7'h29);
      midiSelN = !(!addrEnable && busAddr[10:4] == 7'h33 && !busAddr[3]);
      gameSelN = !(!addrEnable && (busAddr[10:4] == 7'h22 ||
                                   (busAddr[10:4] == 7'h38 && busAddr[3])));
      wideIoN  = mainSelN && gameSelN;
   end
endmodule : isadp_ext_decoder

// ==== tb/isa_dsp_port_decode_tb_top.sv ====
module isa_dsp_port_decode_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam logic [75:0] IDLE_SNAP   = {68'h0, 8'hff};
   localparam int          TIMEOUT_CYC = 5000;
   typedef struct {logic [75:0] val; int cyc;} isadp_note_type;
   logic ref_clk = 1'b0, arst_n = 1'b0, addrEnable = 1'b1, rdN = 1'b1, wrN = 1'b1, dmaActive = 1'b0;
   logic grantN = 1'b1, dspRdN = 1'b1, dspStrN = 1'b1;
   logic [10:0] busAddr = 11'h000;
   logic [3:0]  dspAddr = 4'h0;
   logic mainSelN, midiSelN, gameSelN, wideIoN, noWaitN, chanRdy, hostRdy, holdReqN;
   logic mix1N, mix2N, mixCN, extWrN, extRdN, memWrN, memRdN;
   logic [7:0]  mainRd, mainWr, gameRd, gameWr;
   logic [1:0]  midiRd, midiWr;
   logic [15:0] dspRd, dspWr;
   logic [75:0] curSnap, prevSnap = {68'h0, 8'hff};
   logic [31:0] r, seed = 32'hbc5a1342;
   isadp_note_type notes[$];
   isadp_note_type note;
   int cyc = 0, n_errors = 0, n_checks = 0;
   logic [7:0] daMask;

   isadp_ext_decoder u_dec (.addrEnable(addrEnable), .busAddr(busAddr), .mainSelN(mainSelN),
      .midiSelN(midiSelN), .gameSelN(gameSelN), .wideIoN(wideIoN));
   isadp_port_decode dut (.ref_clk(ref_clk), .arst_n(arst_n), .mainGroupSelectN(mainSelN),
      .midiGroupSelectN(midiSelN), .gameAudioGroupSelectN(gameSelN), .hostReadStrobeInN(rdN),
      .hostWriteStrobeInN(wrN), .hostAddr(busAddr[3:0]), .dmaActive(dmaActive), .hostNoWaitOutN(noWaitN),
      .hostChannelReadyOut(chanRdy), .hostReadyOut(hostRdy), .mainRegRead(mainRd), .mainRegWrite(mainWr),
      .midiRegRead(midiRd), .midiRegWrite(midiWr), .gameRegRead(gameRd), .gameRegWrite(gameWr),
      .processorHoldReqN(holdReqN), .processorBusGrantN(grantN), .processorReadN(dspRdN),
      .processorStrobeN(dspStrN), .processorAddr(dspAddr), .dspPortRead(dspRd), .dspPortWrite(dspWr),
      .mixerLevelOneSelectN(mix1N), .mixerLevelTwoSelectN(mix2N), .mixerControlSelectN(mixCN),
      .extPortWriteSelectN(extWrN), .extPortReadSelectN(extRdN), .extMemoryWriteStrobeN(memWrN),
      .extMemoryReadEnableN(memRdN));

   // Direct access port is judged by its own handshake, not by the scoreboard
   assign daMask = ~(8'h01 << isadp_pkg::DIRECT_ACCESS_IDX);
   always #12.5 ref_clk = ~ref_clk;

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   // Wide enough for the reset snapshot plus the three handshake outputs
   task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s exp %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   task automatic expect_note(input logic [75:0] v);
      isadp_note_type n;
      n.val = v;
      n.cyc = cyc;
      notes.push_back(n);
   endtask : expect_note

   // Group 0 main, 1 MIDI, 2 and 3 the two game audio windows
   task automatic host_tx(input int g, input logic wr, input logic [3:0] off, input logic dma, input int len);
      logic [75:0] e;
      logic [7:0]  v8;
      v8 = 8'h01 << busAddr[3:1];
      e = IDLE_SNAP;
      busAddr = (g == 0) ? {7'h29, off} : (g == 1) ? {7'h33, 1'b0, off[2:0]} :
                (g == 2) ? {7'h22, off} : {7'h38, 1'b1, off[2:0]};
      v8 = 8'h01 << busAddr[3:1];
      if (g == 0) e[75 - 8 * wr -: 8] = v8;
      else if (g == 1) e[59 - 2 * wr -: 2] = 2'b01 << busAddr[0];
      else e[55 - 8 * wr -: 8] = v8;
      e[0] = dma;
      @(posedge ref_clk);
      #2;
      addrEnable = 1'b0;
      dmaActive  = dma;
      rdN = wr;
      wrN = !wr;
      expect_note(e);
      repeat (len) @(posedge ref_clk);
      #2;
      check("wideIoN", wideIoN, g == 1);
      {rdN, wrN, addrEnable, dmaActive} = 4'he;
   endtask : host_tx

   task automatic dsp_tx(input logic [3:0] p, input logic rd, input int len);
      logic [75:0] e;
      e = IDLE_SNAP;
      e[(rd ? 24 : 8) + p] = 1'b1;
      e[7] = !(!rd && p[3:1] == isadp_pkg::PAIR_MIX_ONE);
      e[6] = !(!rd && p[3:1] == isadp_pkg::PAIR_MIX_TWO);
      e[5] = !(!rd && p[3:1] == isadp_pkg::PAIR_MIX_CTL);
      e[4] = !(!rd && p[3:1] == isadp_pkg::PAIR_EXT_PORT);
      e[3] = !(rd && p[3:1] == isadp_pkg::PAIR_EXT_PORT);
      e[2] = !(!rd && p == isadp_pkg::PORT_TABLE_DATA);
      e[1] = !(rd && p == isadp_pkg::PORT_TABLE_DATA);
      @(posedge ref_clk);
      #2;
      dspAddr = p;
      dspRdN  = !rd;
      dspStrN = 1'b0;
      expect_note(e);
      repeat (len) @(posedge ref_clk);
      #2;
      {dspStrN, dspRdN} = 2'b11;
   endtask : dsp_tx

   // Grant may come fast, slow or never before the host gives up
   task automatic direct_tx(input int delay, input logic abort);
      @(posedge ref_clk);
      #2;
      busAddr = {7'h29, 4'h8};
      {addrEnable, rdN} = 2'b00;
      repeat (3) @(posedge ref_clk);
      #2;
      check("holdReqN", holdReqN, 1'b0);
      check("noWaitN", noWaitN, 1'b1);
      repeat (delay) @(posedge ref_clk);
      #2;
      check("chanRdy", {chanRdy, hostRdy}, 2'b00);
      if (!abort) begin
         grantN = 1'b0;
         repeat (3) @(posedge ref_clk);
         #2;
         check("chanRdy", {chanRdy, hostRdy}, 2'b11);
      end
      {addrEnable, rdN} = 2'b11;
      repeat (3) @(posedge ref_clk);
      #2;
      check("holdReqN", {holdReqN, hostRdy}, 2'b10);
      grantN = 1'b1;
   endtask : direct_tx

   // ------------------------------------------------------------
   // Scoreboard and watchdog
   // ------------------------------------------------------------
   // Sampled on the falling edge so registered outputs have settled
   always @(negedge ref_clk) begin
      curSnap = {mainRd & daMask, mainWr & daMask, midiRd, midiWr, gameRd, gameWr, dspRd, dspWr,
                 mix1N, mix2N, mixCN, extWrN, extRdN, memWrN, memRdN, noWaitN};
      if (arst_n && curSnap !== IDLE_SNAP && prevSnap === IDLE_SNAP) begin
         if (notes.size() == 0) check("spurious", curSnap, IDLE_SNAP);
         else begin
            note = notes.pop_front();
            check("decode", curSnap, note.val);
            check("latency", cyc - note.cyc, 76'h3);
         end
      end
      prevSnap = curSnap;
   end

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == TIMEOUT_CYC) begin
         n_errors++;
         $display("[ERR] watchdog exp done seen running");
         stop_test();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge ref_clk);
      #2;
      check("reset", {holdReqN, chanRdy, hostRdy, curSnap}, {3'b110, IDLE_SNAP});
      repeat (10) @(posedge ref_clk);
      #2;
      arst_n = 1'b1;
      for (int i = 0; i < 40; i++) begin
         r = $random(seed);
         host_tx(r[1:0], r[6], (r[1:0] == 2'd0 && r[5:3] == 3'd4) ? r[5:2] ^ 4'h8 : r[5:2],
                 r[7] & r[8], 1 + r[10:9]);
      end
      for (int p = 0; p < 32; p++) begin
         r = $random(seed);
         dsp_tx(p[3:0], p[4], 1 + r[1:0]);
      end
      // Select alone and strobe alone must both stay silent
      @(posedge ref_clk);
      #2;
      busAddr = {7'h29, 4'h2};
      addrEnable = 1'b0;
      repeat (6) @(posedge ref_clk);
      #2;
      {addrEnable, rdN, wrN} = 3'b100;
      repeat (6) @(posedge ref_clk);
      #2;
      check("idle", curSnap, IDLE_SNAP);
      {rdN, wrN} = 2'b11;
      direct_tx(0, 1'b0);
      direct_tx(40, 1'b0);
      direct_tx(5, 1'b1);
      repeat (8) @(posedge ref_clk);
      check("pending", notes.size(), 76'h0);
      stop_test();
   end
endmodule : isa_dsp_port_decode_tb_top
